// ==== rtl/irq_seq_params.svh ====
// Constants for the interrupt entry and exit sequencer
// How it works
// - Maskable interrupts serviced only with mask clear
// - Masked requests stay pending until unmasked
// - Reset leaves the global mask flag set
// - Entry waits for current instruction end
// - Entry pushes PC, X, A, condition_code
// - Entry sets the global mask flag
// - Load vector of serviced source into PC
// - Return pops registers, restoring the mask flag
// - Service routine not preempted by maskable requests
// - Fixed priority picks among simultaneous requests
// - Any request wakes the core from wait
// - Only external sources and designated peripheral sources wake from halt
// - Software trap enters regardless of mask flag
// - Edge request latched, cleared on entry
// - Low enabled NAND pin masks external request
// - Peripheral request needs enable and clear mask
// - Sensitivity change discards pending external request
`ifndef IRQ_SEQ_PARAMS_SVH
`define IRQ_SEQ_PARAMS_SVH

// ----------------------------------------
// Condition code layout
// ----------------------------------------
`define COND_MASK_BIT  3
`define MASK_RESET     1'b1

// ----------------------------------------
// Vectors
// ----------------------------------------
`define VEC_TRAP       16'hfffc
`define VEC_SRC0       16'hfffa

// ----------------------------------------
// Stack sequence
// ----------------------------------------
`define STACK_BYTES    3'h5
`define STACK_LAST     3'h4
`define CNT_ZERO       3'h0
`define CNT_ONE        3'h1

// ----------------------------------------
// External sensitivity codes
// ----------------------------------------
`define SENS_FALL_LOW  2'h0
`define SENS_RISE      2'h1
`define SENS_FALL      2'h2
`define SENS_BOTH      2'h3
`define PIN_IDLE       1'b1

`endif

// ==== rtl/irq_seq_pkg.sv ====
// Types shared by the interrupt sequencer files
package irq_seq_pkg;

  typedef enum logic [2:0] {
    OP_NONE   = 3'h0,
    OP_UNMASK = 3'h1,   // unmask_op
    OP_MASK   = 3'h2,   // mask_set_op
    OP_IDLE   = 3'h3,   // idle_until_event_op
    OP_RETURN = 3'h4,   // service_return_op
    OP_TRAP   = 3'h5,
    OP_HALT   = 3'h6
  } op_t;

  typedef enum logic [2:0] {
    ST_RUN  = 3'h0,
    ST_PUSH = 3'h1,
    ST_VECT = 3'h3,
    ST_POP  = 3'h2,
    ST_WAIT = 3'h6,
    ST_HALT = 3'h7
  } seq_state_t;

  typedef enum logic [2:0] {
    SEL_PCL  = 3'h0,
    SEL_PCH  = 3'h1,
    SEL_X    = 3'h2,
    SEL_A    = 3'h3,
    SEL_COND = 3'h4
  } reg_sel_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  x;
    logic [7:0]  a;
    logic [7:0]  cond;
  } core_regs_t;

  typedef struct packed {
    logic       push;
    logic       pop;
    logic [7:0] wdata;
  } stack_req_t;

  typedef struct packed {
    logic       we;
    reg_sel_t   sel;
    logic [7:0] data;
  } restore_t;

endpackage

// ==== rtl/ext_edge_latch.sv ====
// One external interrupt source: synchroniser, sensitivity and request latch
`timescale 1ns/1ps
`include "irq_seq_params.svh"
module ext_edge_latch (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Pin side
  input  wire logic       pin,
  input  wire logic       low_mask,
  input  wire logic [1:0] sens,
  // Sequencer side
  input  wire logic       ack,
  output logic            req
);

  logic       s1_q;
  logic       s2_q;
  logic       s3_q;
  logic       lvl_q;
  logic       latch_q;
  logic [1:0] sens_q;
  logic       stable;
  logic       rise;
  logic       fall;
  logic       hit;
  logic       level_low;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= `PIN_IDLE;
      s2_q <= `PIN_IDLE;
      s3_q <= `PIN_IDLE;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign stable = (s2_q == s3_q);
  assign rise   = stable && s3_q && !lvl_q;
  assign fall   = stable && !s3_q && lvl_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= `PIN_IDLE;
    end else if (stable) begin
      lvl_q <= s3_q;
    end
  end

  always_comb begin
    unique case (sens)
      `SENS_FALL_LOW: hit = fall;
      `SENS_RISE:     hit = rise;
      `SENS_FALL:     hit = fall;
      `SENS_BOTH:     hit = rise || fall;
    endcase
  end

  assign level_low = (sens == `SENS_FALL_LOW) && !lvl_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sens_q <= `SENS_FALL_LOW;
    end else begin
      sens_q <= sens;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= 1'b0;
    end else if (sens != sens_q) begin
      latch_q <= 1'b0;
    end else if (hit && !low_mask) begin
      latch_q <= 1'b1;
    end else if (ack) begin
      latch_q <= 1'b0;
    end
  end

  assign req = !low_mask && (latch_q || level_low);

  a_sens_discard: assert property (@(posedge clk) disable iff (!rst_n)
    (sens != sens_q) |=> !latch_q)
    else $error("pending request kept over sensitivity change");

  a_low_masks: assert property (@(posedge clk) disable iff (!rst_n)
    low_mask && !latch_q |=> !latch_q)
    else $error("edge latched while pin mask low");

endmodule

// ==== rtl/fixed_prio_pick.sv ====
// Fixed priority pick: lowest set index wins
`timescale 1ns/1ps
module fixed_prio_pick #(
  parameter int N  = 8,
  parameter int IW = 3
) (
  // Requests
  input  wire logic [N-1:0]  req,
  // Winner
  output logic               valid,
  output logic [IW-1:0]      idx
);

  always_comb begin
    valid = 1'b0;
    idx   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        valid = 1'b1;
        idx   = IW'(i);
      end
    end
  end

endmodule

// ==== rtl/cpu_interrupt_sequencer.sv ====
// Interrupt entry and exit sequencer of the core
`timescale 1ns/1ps
`include "irq_seq_params.svh"
module cpu_interrupt_sequencer #(
  parameter int                N_EXT     = 5,
  parameter int                N_PER     = 6,
  parameter logic [N_PER-1:0]  HALT_WAKE = '0
) (
  // Clock and reset
  input  wire logic                       MCLK,
  input  wire logic                       NRST,
  // Instruction sequencer
  input  wire logic                       INSTR_DONE,
  input  wire irq_seq_pkg::op_t           OP_CODE,
  input  wire irq_seq_pkg::core_regs_t    CORE_REGS,
  // Stack read data, one cycle after pop
  input  wire logic [7:0]                 STACK_RDATA,
  // External sources
  input  wire logic [N_EXT-1:0]           EXT_PIN,
  input  wire logic [N_EXT-1:0]           EXT_LOW_MASK,
  input  wire logic [2*N_EXT-1:0]         EXT_SENS,
  // Peripheral sources
  input  wire logic [N_PER-1:0]           PERIPH_FLAG,
  input  wire logic [N_PER-1:0]           PERIPH_EN,
  // Core control
  output logic                            MASK_FLAG,
  output logic                            CORE_HOLD,
  output logic                            SLEEPING,
  output logic                            PC_LOAD,
  output logic [15:0]                     PC_VALUE,
  // Stack and register restore
  output irq_seq_pkg::stack_req_t         STACK_OUT,
  output irq_seq_pkg::restore_t           RESTORE
);

  localparam int N_SRC = N_EXT + N_PER;
  localparam int IW    = $clog2(N_SRC);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  irq_seq_pkg::seq_state_t state_q;
  irq_seq_pkg::seq_state_t state_d;
  irq_seq_pkg::core_regs_t saved_q;
  logic                    mask_q;
  logic                    mask_d;
  logic [2:0]              cnt_q;
  logic                    trap_q;
  logic [IW-1:0]           idx_q;
  logic                    pop_pend_q;
  irq_seq_pkg::reg_sel_t   pop_sel_q;
  logic [N_EXT-1:0]        ext_req;
  logic [N_EXT-1:0]        ext_ack;
  logic [N_PER-1:0]        per_req;
  logic [N_SRC-1:0]        all_req;
  logic                    halt_req;
  logic                    pick_valid;
  logic [IW-1:0]           pick_idx;
  logic                    at_boundary;
  logic                    take_trap;
  logic                    take_irq;
  logic                    entering;
  logic [15:0]             vec_addr;
  logic [7:0]              push_byte;
  irq_seq_pkg::reg_sel_t   pop_sel;

  // ----------------------------------------
  // External sources
  // ----------------------------------------
  for (genvar g = 0; g < N_EXT; g++) begin : g_ext
    ext_edge_latch u_ext (
      .clk      (MCLK),
      .rst_n    (NRST),
      .pin      (EXT_PIN[g]),
      .low_mask (EXT_LOW_MASK[g]),
      .sens     (EXT_SENS[2*g +: 2]),
      .ack      (ext_ack[g]),
      .req      (ext_req[g])
    );
    assign ext_ack[g] = (state_q == irq_seq_pkg::ST_VECT) && !trap_q && (idx_q == IW'(g));
  end

  // ----------------------------------------
  // Peripheral sources and priority
  // ----------------------------------------
  assign per_req  = PERIPH_FLAG & PERIPH_EN;
  assign all_req  = {per_req, ext_req};
  assign halt_req = (|ext_req) || (|(per_req & HALT_WAKE));

  fixed_prio_pick #(
    .N  (N_SRC),
    .IW (IW)
  ) u_pick (
    .req   (all_req),
    .valid (pick_valid),
    .idx   (pick_idx)
  );

  // ----------------------------------------
  // Entry decision
  // ----------------------------------------
  assign at_boundary = (state_q == irq_seq_pkg::ST_RUN) && INSTR_DONE;
  assign take_trap   = at_boundary && (OP_CODE == irq_seq_pkg::OP_TRAP);
  assign take_irq    = !mask_q && pick_valid && !take_trap &&
                       (at_boundary || (state_q == irq_seq_pkg::ST_WAIT) ||
                        (state_q == irq_seq_pkg::ST_HALT && halt_req));
  assign entering    = take_trap || take_irq;
  assign vec_addr    = trap_q ? `VEC_TRAP : 16'(`VEC_SRC0 - {idx_q, 1'b0});

  // ----------------------------------------
  // Sequence state
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      irq_seq_pkg::ST_RUN: begin
        if (entering) begin
          state_d = irq_seq_pkg::ST_PUSH;
        end else if (at_boundary) begin
          unique case (OP_CODE)
            irq_seq_pkg::OP_RETURN: state_d = irq_seq_pkg::ST_POP;
            irq_seq_pkg::OP_IDLE:   state_d = irq_seq_pkg::ST_WAIT;
            irq_seq_pkg::OP_HALT:   state_d = irq_seq_pkg::ST_HALT;
            default:                state_d = irq_seq_pkg::ST_RUN;
          endcase
        end
      end
      irq_seq_pkg::ST_PUSH: begin
        if (cnt_q == `STACK_LAST) begin
          state_d = irq_seq_pkg::ST_VECT;
        end
      end
      irq_seq_pkg::ST_VECT: state_d = irq_seq_pkg::ST_RUN;
      irq_seq_pkg::ST_POP: begin
        if (pop_pend_q && pop_sel_q == irq_seq_pkg::SEL_PCL) begin
          state_d = irq_seq_pkg::ST_RUN;
        end
      end
      irq_seq_pkg::ST_WAIT: begin
        if (take_irq) begin
          state_d = irq_seq_pkg::ST_PUSH;
        end
      end
      irq_seq_pkg::ST_HALT: begin
        if (take_irq) begin
          state_d = irq_seq_pkg::ST_PUSH;
        end else if (halt_req) begin
          state_d = irq_seq_pkg::ST_RUN;
        end
      end
      default: state_d = irq_seq_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= irq_seq_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Global mask flag
  // ----------------------------------------
  always_comb begin
    mask_d = mask_q;
    if (entering) begin
      mask_d = 1'b1;
    end else if (pop_pend_q && pop_sel_q == irq_seq_pkg::SEL_COND) begin
      mask_d = STACK_RDATA[`COND_MASK_BIT];
    end else if (at_boundary) begin
      unique case (OP_CODE)
        irq_seq_pkg::OP_UNMASK: mask_d = 1'b0;
        irq_seq_pkg::OP_MASK:   mask_d = 1'b1;
        irq_seq_pkg::OP_IDLE:   mask_d = 1'b0;
        default:                mask_d = mask_q;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      mask_q <= `MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------
  // Captured context and source
  // ----------------------------------------
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      saved_q <= '0;
      trap_q  <= 1'b0;
      idx_q   <= '0;
    end else if (entering) begin
      saved_q    <= CORE_REGS;
      saved_q.cond <= {CORE_REGS.cond[7:`COND_MASK_BIT+1], mask_q, CORE_REGS.cond[`COND_MASK_BIT-1:0]};
      trap_q     <= take_trap;
      idx_q      <= pick_idx;
    end
  end

  // ----------------------------------------
  // Byte counter for push and pop
  // ----------------------------------------
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      cnt_q <= `CNT_ZERO;
    end else if (state_d != state_q) begin
      cnt_q <= `CNT_ZERO;
    end else if (cnt_q != `STACK_BYTES) begin
      cnt_q <= cnt_q + `CNT_ONE;
    end
  end

  always_comb begin
    unique case (cnt_q)
      3'h0:    push_byte = saved_q.pc[7:0];
      3'h1:    push_byte = saved_q.pc[15:8];
      3'h2:    push_byte = saved_q.x;
      3'h3:    push_byte = saved_q.a;
      default: push_byte = saved_q.cond;
    endcase
    unique case (cnt_q)
      3'h1:    pop_sel = irq_seq_pkg::SEL_COND;
      3'h2:    pop_sel = irq_seq_pkg::SEL_A;
      3'h3:    pop_sel = irq_seq_pkg::SEL_X;
      3'h4:    pop_sel = irq_seq_pkg::SEL_PCH;
      default: pop_sel = irq_seq_pkg::SEL_PCL;
    endcase
  end

  // ----------------------------------------
  // Stack requests
  // ----------------------------------------
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      STACK_OUT <= '0;
    end else begin
      STACK_OUT.push  <= (state_q == irq_seq_pkg::ST_PUSH);
      STACK_OUT.wdata <= push_byte;
      STACK_OUT.pop   <= (state_q == irq_seq_pkg::ST_POP) && (cnt_q < `STACK_BYTES);
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      pop_pend_q <= 1'b0;
      pop_sel_q  <= irq_seq_pkg::SEL_COND;
    end else begin
      pop_pend_q <= STACK_OUT.pop;
      pop_sel_q  <= pop_sel;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      RESTORE <= '0;
    end else begin
      RESTORE.we   <= pop_pend_q;
      RESTORE.sel  <= pop_sel_q;
      RESTORE.data <= STACK_RDATA;
    end
  end

  // ----------------------------------------
  // Vector load and core control
  // ----------------------------------------
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      PC_LOAD  <= 1'b0;
      PC_VALUE <= '0;
    end else begin
      PC_LOAD  <= (state_q == irq_seq_pkg::ST_VECT);
      PC_VALUE <= vec_addr;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      MASK_FLAG <= `MASK_RESET;
      CORE_HOLD <= 1'b0;
      SLEEPING  <= 1'b0;
    end else begin
      MASK_FLAG <= mask_d;
      CORE_HOLD <= (state_d != irq_seq_pkg::ST_RUN);
      SLEEPING  <= (state_d == irq_seq_pkg::ST_WAIT) || (state_d == irq_seq_pkg::ST_HALT);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  a_irq_needs_unmask: assert property (
    (state_q != irq_seq_pkg::ST_PUSH ##1 state_q == irq_seq_pkg::ST_PUSH && !trap_q) |-> !$past(mask_q, 1))
    else $error("maskable entry with mask flag set");

  a_push_five_bytes: assert property (
    (state_q == irq_seq_pkg::ST_RUN ##1 state_q == irq_seq_pkg::ST_PUSH) |=> STACK_OUT.push [*5] ##1 !STACK_OUT.push)
    else $error("entry did not push five bytes");

  a_entry_sets_mask: assert property (
    state_q == irq_seq_pkg::ST_PUSH |-> mask_q && MASK_FLAG)
    else $error("mask flag clear during entry");

  a_vector_loaded: assert property (
    state_q == irq_seq_pkg::ST_VECT |=> PC_LOAD && PC_VALUE == $past(vec_addr) && state_q == irq_seq_pkg::ST_RUN)
    else $error("vector not loaded after stacking");

  a_return_restores: assert property (
    at_boundary && OP_CODE == irq_seq_pkg::OP_RETURN |-> ##[7:8] state_q == irq_seq_pkg::ST_RUN)
    else $error("return sequence length wrong");

  a_prio_lowest_wins: assert property (
    pick_valid |-> all_req[pick_idx] && ((all_req & ((N_SRC'(1) << pick_idx) - N_SRC'(1))) == '0))
    else $error("lower priority source picked");

  a_wait_any_wakes: assert property (
    state_q == irq_seq_pkg::ST_WAIT && pick_valid && !mask_q |=> state_q == irq_seq_pkg::ST_PUSH)
    else $error("wait not left on request");

  a_halt_stays: assert property (
    state_q == irq_seq_pkg::ST_HALT && !halt_req |=> state_q == irq_seq_pkg::ST_HALT)
    else $error("halt left without wake source");

  a_trap_always_taken: assert property (
    take_trap |=> state_q == irq_seq_pkg::ST_PUSH && trap_q && mask_q)
    else $error("trap not entered");

  a_idle_unmasks: assert property (
    at_boundary && OP_CODE == irq_seq_pkg::OP_IDLE && !entering |=> !mask_q && state_q == irq_seq_pkg::ST_WAIT)
    else $error("idle did not clear mask");

  c_irq_entry:  cover property (take_irq && at_boundary);
  c_trap_entry: cover property (take_trap);
  c_wait_wake:  cover property (state_q == irq_seq_pkg::ST_WAIT ##1 state_q == irq_seq_pkg::ST_PUSH);
  c_return:     cover property (RESTORE.we && RESTORE.sel == irq_seq_pkg::SEL_PCL);

endmodule

// ==== dv/irq_src_model.sv ====
// Model of the interrupt sources: external pins and peripheral flags
`timescale 1ns/1ps
module irq_src_model #(
  parameter int N_EXT = 5,
  parameter int N_PER = 6
) (
  // Clock
  input  wire logic               clk,
  // Source levels
  output logic [N_EXT-1:0]        ext_pin,
  output logic [N_EXT-1:0]        ext_low_mask,
  output logic [2*N_EXT-1:0]      ext_sens,
  output logic [N_PER-1:0]        per_flag,
  output logic [N_PER-1:0]        per_en
);
  initial begin
    ext_pin = '1;
    ext_low_mask = '0;
    ext_sens = {N_EXT{2'h2}};
    per_flag = '0;
    per_en = '0;
  end

  // Pin level, held long enough to pass the synchroniser
  task automatic pin(input int g, input logic v);
    @(posedge clk);
    ext_pin[g] <= v;
    repeat (5) @(posedge clk);
  endtask

  task automatic sens(input int g, input logic [1:0] s);
    @(posedge clk);
    ext_sens[2*g +: 2] <= s;
  endtask

  task automatic lowm(input int g, input logic v);
    @(posedge clk);
    ext_low_mask[g] <= v;
  endtask

  // Flag stays up until the routine clears it
  task automatic per(input int k, input logic f, input logic e);
    @(posedge clk);
    per_flag[k] <= f;
    per_en[k] <= e;
  endtask
endmodule

// ==== dv/cpu_interrupt_sequencer_test.sv ====
// Self-checking bench for the interrupt entry and exit sequencer
`timescale 1ns/1ps
module cpu_interrupt_sequencer_test;
  localparam int               N_EXT     = 5;
  localparam int               N_PER     = 6;
  localparam logic [N_PER-1:0] HALT_WAKE = 6'h02;
  localparam irq_seq_pkg::core_regs_t REGS = '{16'h1234, 8'h56, 8'h78, 8'ha5};

  logic                    MCLK        = 1'b0;
  logic                    NRST        = 1'b0;
  logic                    INSTR_DONE  = 1'b0;
  irq_seq_pkg::op_t        OP_CODE     = irq_seq_pkg::OP_NONE;
  logic [7:0]              STACK_RDATA = 8'h00;
  logic [N_EXT-1:0]        EXT_PIN;
  logic [N_EXT-1:0]        EXT_LOW_MASK;
  logic [2*N_EXT-1:0]      EXT_SENS;
  logic [N_PER-1:0]        PERIPH_FLAG;
  logic [N_PER-1:0]        PERIPH_EN;
  logic                    MASK_FLAG;
  logic                    CORE_HOLD;
  logic                    SLEEPING;
  logic                    PC_LOAD;
  logic [15:0]             PC_VALUE;
  irq_seq_pkg::stack_req_t STACK_OUT;
  irq_seq_pkg::restore_t   RESTORE;
  logic [7:0]              stack [$];
  logic [7:0]              pushed [$];
  int                      miscompares = 0;
  int                      n_checks    = 0;

  always #10 MCLK = ~MCLK;

  cpu_interrupt_sequencer #(
    .N_EXT     (N_EXT),
    .N_PER     (N_PER),
    .HALT_WAKE (HALT_WAKE)
  ) cpu_interrupt_sequencer_i (
    .MCLK         (MCLK),
    .NRST         (NRST),
    .INSTR_DONE   (INSTR_DONE),
    .OP_CODE      (OP_CODE),
    .CORE_REGS    (REGS),
    .STACK_RDATA  (STACK_RDATA),
    .EXT_PIN      (EXT_PIN),
    .EXT_LOW_MASK (EXT_LOW_MASK),
    .EXT_SENS     (EXT_SENS),
    .PERIPH_FLAG  (PERIPH_FLAG),
    .PERIPH_EN    (PERIPH_EN),
    .MASK_FLAG    (MASK_FLAG),
    .CORE_HOLD    (CORE_HOLD),
    .SLEEPING     (SLEEPING),
    .PC_LOAD      (PC_LOAD),
    .PC_VALUE     (PC_VALUE),
    .STACK_OUT    (STACK_OUT),
    .RESTORE      (RESTORE)
  );

  irq_src_model #(.N_EXT(N_EXT), .N_PER(N_PER)) irq_src_model_i (
    .clk          (MCLK),
    .ext_pin      (EXT_PIN),
    .ext_low_mask (EXT_LOW_MASK),
    .ext_sens     (EXT_SENS),
    .per_flag     (PERIPH_FLAG),
    .per_en       (PERIPH_EN)
  );

  // Stack memory; read data changes every cycle when not valid
  always @(posedge MCLK) begin
    if (STACK_OUT.push) begin
      stack.push_back(STACK_OUT.wdata);
    end
    if (STACK_OUT.pop && stack.size() > 0) begin
      STACK_RDATA <= stack.pop_back();
    end else begin
      STACK_RDATA <= ~STACK_RDATA;
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic fail_wait;
    miscompares++;
    $display("unexpected at %0t: wait ran out", $time);
    complete_run();
  endtask

  function automatic logic [15:0] vec(input int n);
    return 16'hfffa - 16'(2 * n);
  endfunction

  // Byte k in push order, with the stacked mask bit m
  function automatic logic [7:0] stk(input int k, input logic m);
    logic [7:0] b [5];
    b = '{REGS.pc[7:0], REGS.pc[15:8], REGS.x, REGS.a, {REGS.cond[7:4], m, REGS.cond[2:0]}};
    return b[k];
  endfunction

  task automatic instr(input irq_seq_pkg::op_t op);
    @(posedge MCLK);
    INSTR_DONE <= 1'b1;
    OP_CODE <= op;
    @(posedge MCLK);
    INSTR_DONE <= 1'b0;
    OP_CODE <= irq_seq_pkg::OP_NONE;
  endtask

  task automatic settle;
    @(posedge MCLK);
    #1;
  endtask

  task automatic expect_quiet(input int n);
    repeat (n) begin
      settle();
      check({PC_LOAD, STACK_OUT.push}, 16'h0000);
    end
  endtask

  task automatic expect_entry(input logic [15:0] v, input logic m);
    int i;
    pushed.delete();
    for (i = 0; i < 14 && !PC_LOAD; i++) begin
      settle();
      if (STACK_OUT.push) begin
        pushed.push_back(STACK_OUT.wdata);
      end
    end
    if (!PC_LOAD) begin
      fail_wait();
    end
    check(PC_VALUE, v);
    check(MASK_FLAG, 1'b1);
    check(pushed.size(), 16'h0005);
    for (i = 0; i < 5; i++) begin
      check(pushed[i], stk(i, m));
    end
  endtask

  task automatic expect_return(input logic m);
    irq_seq_pkg::reg_sel_t sel [5];
    int i;
    int n;
    sel = '{irq_seq_pkg::SEL_COND, irq_seq_pkg::SEL_A, irq_seq_pkg::SEL_X,
            irq_seq_pkg::SEL_PCH, irq_seq_pkg::SEL_PCL};
    n = 0;
    instr(irq_seq_pkg::OP_RETURN);
    for (i = 0; i < 14 && (n < 5 || CORE_HOLD); i++) begin
      settle();
      if (RESTORE.we && n < 5) begin
        check(RESTORE.sel, sel[n]);
        check(RESTORE.data, stk(4 - n, m));
        n++;
      end
    end
    if (CORE_HOLD || n < 5) begin
      fail_wait();
    end
    check(MASK_FLAG, m);
  endtask

  task automatic unmask_go;
    instr(irq_seq_pkg::OP_UNMASK);
    settle();
    if (!CORE_HOLD) begin
      instr(irq_seq_pkg::OP_NONE);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic run_trap;
    instr(irq_seq_pkg::OP_TRAP);
    expect_entry(16'hfffc, 1'b1);
    irq_src_model_i.per(0, 1'b1, 1'b1);
    instr(irq_seq_pkg::OP_NONE);
    expect_quiet(8);
    irq_src_model_i.per(0, 1'b0, 1'b0);
    expect_return(1'b1);
  endtask

  task automatic run_enable;
    irq_src_model_i.per(1, 1'b1, 1'b1);
    instr(irq_seq_pkg::OP_NONE);
    expect_quiet(8);
    irq_src_model_i.per(1, 1'b1, 1'b0);
    instr(irq_seq_pkg::OP_UNMASK);
    settle();
    check(MASK_FLAG, 1'b0);
    instr(irq_seq_pkg::OP_NONE);
    expect_quiet(6);
    irq_src_model_i.per(1, 1'b1, 1'b1);
    expect_quiet(4);
    instr(irq_seq_pkg::OP_NONE);
    expect_entry(vec(N_EXT + 1), 1'b0);
    irq_src_model_i.per(1, 1'b0, 1'b0);
    expect_return(1'b0);
    instr(irq_seq_pkg::OP_MASK);
    settle();
    check(MASK_FLAG, 1'b1);
  endtask

  task automatic run_prio;
    irq_src_model_i.pin(2, 1'b0);
    irq_src_model_i.per(0, 1'b1, 1'b1);
    instr(irq_seq_pkg::OP_NONE);
    expect_quiet(4);
    unmask_go();
    expect_entry(vec(2), 1'b0);
    expect_return(1'b0);
    instr(irq_seq_pkg::OP_NONE);
    expect_entry(vec(N_EXT), 1'b0);
    irq_src_model_i.per(0, 1'b0, 1'b0);
    irq_src_model_i.pin(2, 1'b1);
    expect_return(1'b0);
  endtask

  task automatic run_discard;
    instr(irq_seq_pkg::OP_MASK);
    irq_src_model_i.pin(1, 1'b0);
    irq_src_model_i.pin(1, 1'b1);
    irq_src_model_i.sens(1, 2'h3);
    irq_src_model_i.sens(1, 2'h2);
    instr(irq_seq_pkg::OP_UNMASK);
    instr(irq_seq_pkg::OP_NONE);
    expect_quiet(8);
  endtask

  task automatic run_lowmask;
    irq_src_model_i.sens(3, 2'h1);
    irq_src_model_i.lowm(3, 1'b1);
    irq_src_model_i.pin(3, 1'b0);
    irq_src_model_i.pin(3, 1'b1);
    instr(irq_seq_pkg::OP_NONE);
    expect_quiet(8);
    irq_src_model_i.lowm(3, 1'b0);
    irq_src_model_i.sens(3, 2'h2);
  endtask

  // Falling and low mode: the low level keeps asking after entry
  task automatic run_level;
    irq_src_model_i.sens(4, 2'h0);
    irq_src_model_i.pin(4, 1'b0);
    repeat (2) begin
      instr(irq_seq_pkg::OP_NONE);
      expect_entry(vec(4), 1'b0);
      expect_return(1'b0);
    end
    irq_src_model_i.pin(4, 1'b1);
    irq_src_model_i.sens(4, 2'h2);
    instr(irq_seq_pkg::OP_NONE);
    expect_quiet(4);
  endtask

  task automatic run_idle;
    instr(irq_seq_pkg::OP_MASK);
    instr(irq_seq_pkg::OP_IDLE);
    settle();
    check(MASK_FLAG, 1'b0);
    check(SLEEPING, 1'b1);
    expect_quiet(3);
    irq_src_model_i.per(2, 1'b1, 1'b1);
    expect_entry(vec(N_EXT + 2), 1'b0);
    irq_src_model_i.per(2, 1'b0, 1'b0);
    expect_return(1'b0);
  endtask

  task automatic run_halt;
    instr(irq_seq_pkg::OP_HALT);
    irq_src_model_i.per(0, 1'b1, 1'b1);
    expect_quiet(8);
    check(SLEEPING, 1'b1);
    irq_src_model_i.per(0, 1'b0, 1'b0);
    irq_src_model_i.per(1, 1'b1, 1'b1);
    expect_entry(vec(N_EXT + 1), 1'b0);
    irq_src_model_i.per(1, 1'b0, 1'b0);
    expect_return(1'b0);
  endtask

  initial begin
    repeat (5) @(posedge MCLK);
    NRST <= 1'b1;
    settle();
    check(MASK_FLAG, 1'b1);
    check(CORE_HOLD, 1'b0);
    repeat (3) @(posedge MCLK);
    run_trap();
    run_enable();
    run_prio();
    run_discard();
    run_lowmask();
    run_level();
    run_idle();
    run_halt();
    complete_run();
  end
endmodule
